//--- cas_alert_bank.sv
// status register bank for cell, auxiliary, balancing and supply alerts
//
// Overview of operation
// - aux hot flags follow input each acquisition
// - cell undervoltage flag needs enable and low voltage
// - twelve balancing diag flags versus selected threshold
// - highest cell number, ties to highest, resets Fh
// - lowest cell number, ties to highest, resets Fh
// - sticky headroom flag set during acquisition
// - sticky supply overvoltage, blocked while gate set
// - sticky flags clear only on written zero
// - reserved bits always read as zero
//
// Chosen here: strobed register access.
`timescale 1ns/10ps
module cas_alert_bank #(
  parameter int VOLT_W    = cas_pkg::VOLT_W,
  parameter int NUM_CELLS = cas_pkg::NUM_CELLS,
  parameter int NUM_BAL   = cas_pkg::NUM_BAL
) (
  // clock and reset
  input  wire logic                              ref_clk,
  input  wire logic                              rst_b,
  // register port
  input  wire logic [cas_pkg::ADDR_W-1:0]        reg_addr,
  input  wire logic [cas_pkg::DATA_W-1:0]        reg_wr_data,
  input  wire logic                              reg_wr_stb,
  input  wire logic                              reg_rd_stb,
  output logic      [cas_pkg::DATA_W-1:0]        reg_rd_data,
  // acquisition results, same clock domain
  input  wire logic                              acq_done,
  input  wire logic [NUM_CELLS-1:0][VOLT_W-1:0]  cell_volt,
  input  wire logic [VOLT_W-1:0]                 aux0_volt,
  input  wire logic [VOLT_W-1:0]                 aux1_volt,
  input  wire logic [NUM_BAL-1:0][VOLT_W-1:0]    balance_diag_meas,
  input  wire logic                              hv_headroom_low,
  // analog comparator pin, asynchronous
  input  wire logic                              hv_overvoltage_pin,
  // interrupt
  output logic                                   alert_irq
);

  // ==========================================================================
  // helpers
  // ==========================================================================
  // address match, used by the write paths and the status-read detect; the read mux decodes reg_addr directly
  function automatic logic hit(input logic [cas_pkg::ADDR_W-1:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // strict below-threshold test shared by cell and auxiliary comparisons
  function automatic logic below(input logic [VOLT_W-1:0] v, input logic [VOLT_W-1:0] t);
    below = (v < t);
  endfunction

  // ==========================================================================
  // state
  // ==========================================================================
  logic [NUM_CELLS-1:0]             cell_undervoltage_flags_reg;
  logic [NUM_CELLS-1:0]             cell_uv_flags_next;
  logic                             aux0_hot_alert_reg;
  logic                             aux1_hot_alert_reg;
  logic [NUM_BAL-1:0]               balance_diag_flags_reg;
  logic [NUM_BAL-1:0]               bal_flags_next;
  logic [3:0]                       highest_voltage_cell_reg;
  logic [3:0]                       lowest_voltage_cell_reg;
  logic                             supply_headroom_fault_reg;
  logic                             supply_overvoltage_fault_reg;
  logic                             alert_reset_gate_reg;
  logic [cas_pkg::SEL_W-1:0]        balance_diag_select_reg;
  logic [VOLT_W-1:0]                undervoltage_threshold_setting_reg;
  logic [NUM_CELLS-1:0]             undervoltage_alert_enable_reg;
  logic [VOLT_W-1:0]                aux_hot_threshold_reg;
  logic [cas_pkg::IRQ_W-1:0]        irq_status_reg;
  logic [cas_pkg::IRQ_W-1:0]        irq_status_next;
  logic [cas_pkg::IRQ_W-1:0]        irq_mask_reg;
  logic [cas_pkg::DATA_W-1:0]       rd_data_reg;
  logic                             irq_reg;
  logic                             hv_ov_meta_reg;
  logic                             hv_ov_sync_reg;
  logic                             headroom_set;
  logic                             hv_ov_set;
  logic                             aux0_next;
  logic                             aux1_next;
  logic [VOLT_W-1:0]                bal_thresh;
  logic [cas_pkg::IRQ_W-1:0]        irq_events;
  logic                             wr_faults;
  logic                             rd_status;

  cas_extreme_if #(.VOLT_W(VOLT_W), .NUM_CELLS(NUM_CELLS)) ext ();

  // ==========================================================================
  // extreme cell search
  // ==========================================================================
  assign ext.cell_volt = cell_volt;

  cas_extreme_finder #(
    .VOLT_W    (VOLT_W),
    .NUM_CELLS (NUM_CELLS)
  ) u_finder (
    .ext (ext.finder)
  );

  // ==========================================================================
  // pin synchroniser
  // ==========================================================================
  // comparator output is unrelated to ref_clk; only the second stage is read
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hv_ov_meta_reg <= 1'b0;
      hv_ov_sync_reg <= 1'b0;
    end else begin
      hv_ov_meta_reg <= hv_overvoltage_pin;
      hv_ov_sync_reg <= hv_ov_meta_reg;
    end
  end

  // ==========================================================================
  // comparisons made at each acquisition
  // ==========================================================================
  // per-cell undervoltage, gated by its enable bit
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CELLS; gi++) begin : g_cell
      assign cell_uv_flags_next[gi] = undervoltage_alert_enable_reg[gi] &&
                                      below(cell_volt[gi], undervoltage_threshold_setting_reg);
    end
    for (gi = 0; gi < NUM_BAL; gi++) begin : g_bal
      assign bal_flags_next[gi] = (balance_diag_meas[gi] > bal_thresh);
    end
  endgenerate

  // threshold chosen by the diagnostic select field
  assign bal_thresh = VOLT_W'(cas_pkg::BAL_DIAG_THRESH[balance_diag_select_reg]);

  // hot thermistor gives a low input voltage
  assign aux0_next = below(aux0_volt, aux_hot_threshold_reg);
  assign aux1_next = below(aux1_volt, aux_hot_threshold_reg);

  // ==========================================================================
  // live alert flags
  // ==========================================================================
  // recomputed only at acquisition so a flag both sets and clears there;
  // register writes never reach these flops
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cell_undervoltage_flags_reg <= '0;
      aux0_hot_alert_reg          <= 1'b0;
      aux1_hot_alert_reg          <= 1'b0;
      balance_diag_flags_reg      <= '0;
    end else if (acq_done) begin
      cell_undervoltage_flags_reg <= cell_uv_flags_next;
      aux0_hot_alert_reg          <= aux0_next;
      aux1_hot_alert_reg          <= aux1_next;
      balance_diag_flags_reg      <= bal_flags_next;
    end
  end

  // extreme cell numbers reflect the readings at the latest acquisition
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      highest_voltage_cell_reg <= cas_pkg::RST_EXTREME_IDX;
      lowest_voltage_cell_reg  <= cas_pkg::RST_EXTREME_IDX;
    end else if (acq_done) begin
      highest_voltage_cell_reg <= ext.highest_voltage_cell;
      lowest_voltage_cell_reg  <= ext.lowest_voltage_cell;
    end
  end

  // ==========================================================================
  // sticky supply faults
  // ==========================================================================
  assign headroom_set = acq_done && hv_headroom_low;
  assign hv_ov_set    = hv_ov_sync_reg && !alert_reset_gate_reg;
  assign wr_faults    = reg_wr_stb && hit(reg_addr, cas_pkg::OFF_SUPPLY_FAULTS);

  // set is tested first so a fault in the clearing cycle is kept
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      supply_headroom_fault_reg <= 1'b0;
    end else if (headroom_set) begin
      supply_headroom_fault_reg <= 1'b1;
    end else if (wr_faults && !reg_wr_data[cas_pkg::POS_HEADROOM]) begin
      supply_headroom_fault_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      supply_overvoltage_fault_reg <= 1'b0;
    end else if (hv_ov_set) begin
      supply_overvoltage_fault_reg <= 1'b1;
    end else if (wr_faults && !reg_wr_data[cas_pkg::POS_HV_OVERVOLT]) begin
      supply_overvoltage_fault_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // software control registers
  // ==========================================================================
  // the gate starts set so start-up supply glitches are not latched
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      alert_reset_gate_reg    <= cas_pkg::RST_GATE;
      balance_diag_select_reg <= cas_pkg::RST_DIAG_SEL;
    end else if (reg_wr_stb && hit(reg_addr, cas_pkg::OFF_ALERT_CTRL)) begin
      alert_reset_gate_reg    <= reg_wr_data[cas_pkg::POS_GATE];
      balance_diag_select_reg <= reg_wr_data[cas_pkg::POS_DIAG_SEL_LO +: cas_pkg::SEL_W];
    end
  end

  // thresholds and enables used by the comparisons above
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      undervoltage_threshold_setting_reg <= cas_pkg::RST_UV_THRESHOLD;
      undervoltage_alert_enable_reg      <= cas_pkg::RST_UV_ENABLE;
      aux_hot_threshold_reg              <= cas_pkg::RST_AUX_HOT;
    end else if (reg_wr_stb) begin
      if (hit(reg_addr, cas_pkg::OFF_UV_THRESHOLD)) begin
        undervoltage_threshold_setting_reg <= reg_wr_data[VOLT_W-1:0];
      end
      if (hit(reg_addr, cas_pkg::OFF_UV_ENABLE)) begin
        undervoltage_alert_enable_reg <= reg_wr_data[NUM_CELLS-1:0];
      end
      if (hit(reg_addr, cas_pkg::OFF_AUX_HOT_THRESH)) begin
        aux_hot_threshold_reg <= reg_wr_data[VOLT_W-1:0];
      end
    end
  end

  // ==========================================================================
  // interrupt status and mask
  // ==========================================================================
  // events are new alerts: a flag rising, or a sticky fault being latched
  assign irq_events[cas_pkg::POS_IRQ_CELL_UV]  = acq_done && |(cell_uv_flags_next & ~cell_undervoltage_flags_reg);
  assign irq_events[cas_pkg::POS_IRQ_AUX_HOT]  = acq_done && ((aux0_next && !aux0_hot_alert_reg) ||
                                                             (aux1_next && !aux1_hot_alert_reg));
  assign irq_events[cas_pkg::POS_IRQ_BAL_DIAG] = acq_done && |(bal_flags_next & ~balance_diag_flags_reg);
  assign irq_events[cas_pkg::POS_IRQ_HEADROOM] = headroom_set && !supply_headroom_fault_reg;
  assign irq_events[cas_pkg::POS_IRQ_HV_OV]    = hv_ov_set && !supply_overvoltage_fault_reg;

  assign rd_status = reg_rd_stb && hit(reg_addr, cas_pkg::OFF_IRQ_STATUS);

  // a read clears the status, but an event in that same cycle survives
  always_comb begin
    irq_status_next = rd_status ? irq_events : (irq_status_reg | irq_events);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_mask_reg <= cas_pkg::RST_IRQ_MASK;
    end else if (reg_wr_stb && hit(reg_addr, cas_pkg::OFF_IRQ_MASK)) begin
      irq_mask_reg <= reg_wr_data[cas_pkg::IRQ_W-1:0];
    end
  end

  // registered from the next status so the output follows it with no extra lag
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_status_next & irq_mask_reg);
    end
  end

  // ==========================================================================
  // read path
  // ==========================================================================
  // data stands one cycle after the strobe and is zero otherwise;
  // unlisted bits and unmapped addresses return zero
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_reg <= '0;
    end else begin
      rd_data_reg <= '0;
      if (reg_rd_stb) begin
        case (reg_addr)
          cas_pkg::OFF_CELL_UV_ALERTS: begin
            rd_data_reg[cas_pkg::POS_AUX1_HOT] <= aux1_hot_alert_reg;
            rd_data_reg[cas_pkg::POS_AUX0_HOT] <= aux0_hot_alert_reg;
            rd_data_reg[cas_pkg::POS_CELL_UV_LO +: NUM_CELLS] <= cell_undervoltage_flags_reg;
          end
          cas_pkg::OFF_BAL_SW_ALERTS: begin
            rd_data_reg[NUM_BAL-1:0] <= balance_diag_flags_reg;
          end
          cas_pkg::OFF_EXTREME_CELL_IDX: begin
            rd_data_reg[cas_pkg::POS_MAX_CELL_LO +: cas_pkg::IDX_W] <= highest_voltage_cell_reg;
            rd_data_reg[cas_pkg::POS_MIN_CELL_LO +: cas_pkg::IDX_W] <= lowest_voltage_cell_reg;
          end
          cas_pkg::OFF_SUPPLY_FAULTS: begin
            rd_data_reg[cas_pkg::POS_HEADROOM]    <= supply_headroom_fault_reg;
            rd_data_reg[cas_pkg::POS_HV_OVERVOLT] <= supply_overvoltage_fault_reg;
          end
          cas_pkg::OFF_ALERT_CTRL: begin
            rd_data_reg[cas_pkg::POS_GATE] <= alert_reset_gate_reg;
            rd_data_reg[cas_pkg::POS_DIAG_SEL_LO +: cas_pkg::SEL_W] <= balance_diag_select_reg;
          end
          cas_pkg::OFF_UV_THRESHOLD: begin
            rd_data_reg[VOLT_W-1:0] <= undervoltage_threshold_setting_reg;
          end
          cas_pkg::OFF_UV_ENABLE: begin
            rd_data_reg[NUM_CELLS-1:0] <= undervoltage_alert_enable_reg;
          end
          cas_pkg::OFF_AUX_HOT_THRESH: begin
            rd_data_reg[VOLT_W-1:0] <= aux_hot_threshold_reg;
          end
          cas_pkg::OFF_IRQ_STATUS: begin
            rd_data_reg[cas_pkg::IRQ_W-1:0] <= irq_status_reg;
          end
          cas_pkg::OFF_IRQ_MASK: begin
            rd_data_reg[cas_pkg::IRQ_W-1:0] <= irq_mask_reg;
          end
          default: begin
            rd_data_reg <= '0;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign reg_rd_data = rd_data_reg;
  assign alert_irq   = irq_reg;

endmodule

//--- cas_pkg.sv
// package of offsets, field layouts, reset values and thresholds for the alert status bank
package cas_pkg;

  // ==========================================================================
  // widths
  // ==========================================================================
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 16;
  localparam int VOLT_W    = 14;
  localparam int NUM_CELLS = 12;
  localparam int NUM_BAL   = 12;
  localparam int IDX_W     = 4;
  localparam int SEL_W     = 3;
  localparam int IRQ_W     = 5;

  // ==========================================================================
  // register offsets (status bank as printed, control block chosen locally)
  // ==========================================================================
  localparam logic [7:0] OFF_CELL_UV_ALERTS   = 8'h07;
  localparam logic [7:0] OFF_BAL_SW_ALERTS    = 8'h08;
  localparam logic [7:0] OFF_EXTREME_CELL_IDX = 8'h0a;
  localparam logic [7:0] OFF_SUPPLY_FAULTS    = 8'h0b;
  localparam logic [7:0] OFF_ALERT_CTRL       = 8'h10;
  localparam logic [7:0] OFF_UV_THRESHOLD     = 8'h11;
  localparam logic [7:0] OFF_UV_ENABLE        = 8'h12;
  localparam logic [7:0] OFF_AUX_HOT_THRESH   = 8'h13;
  localparam logic [7:0] OFF_IRQ_STATUS       = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK         = 8'h15;

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int POS_AUX1_HOT      = 13;
  localparam int POS_AUX0_HOT      = 12;
  localparam int POS_CELL_UV_LO    = 0;
  localparam int POS_MAX_CELL_LO   = 8;
  localparam int POS_MIN_CELL_LO   = 0;
  localparam int POS_HEADROOM      = 2;
  localparam int POS_HV_OVERVOLT   = 0;
  localparam int POS_GATE          = 0;
  localparam int POS_DIAG_SEL_LO   = 1;
  localparam int POS_IRQ_CELL_UV   = 0;
  localparam int POS_IRQ_AUX_HOT   = 1;
  localparam int POS_IRQ_BAL_DIAG  = 2;
  localparam int POS_IRQ_HEADROOM  = 3;
  localparam int POS_IRQ_HV_OV     = 4;

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [15:0] RST_ALERTS       = 16'h0000;
  localparam logic [3:0]  RST_EXTREME_IDX  = 4'hf;
  localparam logic        RST_GATE         = 1'b1;
  localparam logic [2:0]  RST_DIAG_SEL     = 3'h0;
  localparam logic [13:0] RST_UV_THRESHOLD = 14'h0000;
  localparam logic [11:0] RST_UV_ENABLE    = 12'h000;
  localparam logic [13:0] RST_AUX_HOT      = 14'h0000;
  localparam logic [4:0]  RST_IRQ_MASK     = 5'h00;

  // diagnostic thresholds picked by balance_diag_select, in ADC codes
  localparam logic [7:0][13:0] BAL_DIAG_THRESH = {
    14'h3800, 14'h3000, 14'h2800, 14'h2000, 14'h1800, 14'h1000, 14'h0800, 14'h0400
  };

endpackage

//--- cas_extreme_if.sv
// interface carrying the cell readings to the extreme-cell finder and its answer back
`timescale 1ns/10ps
interface cas_extreme_if #(
  parameter int VOLT_W    = 14,
  parameter int NUM_CELLS = 12
);
  logic [NUM_CELLS-1:0][VOLT_W-1:0] cell_volt;
  logic [3:0]                       highest_voltage_cell;
  logic [3:0]                       lowest_voltage_cell;

  // the bank supplies readings and takes the result
  modport bank   (output cell_volt, input highest_voltage_cell, lowest_voltage_cell);
  modport finder (input cell_volt, output highest_voltage_cell, lowest_voltage_cell);
endinterface

//--- cas_extreme_finder.sv
// combinational search for the cells holding the highest and lowest voltage
`timescale 1ns/10ps
module cas_extreme_finder #(
  parameter int VOLT_W    = 14,
  parameter int NUM_CELLS = 12
) (
  // readings in, cell numbers out
  cas_extreme_if.finder ext
);

  // ==========================================================================
  // linear scan
  // ==========================================================================
  // >= and <= let a later cell win a tie, so ties report the highest number
  always_comb begin
    logic [VOLT_W-1:0] hi_v;
    logic [VOLT_W-1:0] lo_v;
    logic [3:0]        hi_i;
    logic [3:0]        lo_i;
    hi_v = ext.cell_volt[0];
    lo_v = ext.cell_volt[0];
    hi_i = 4'h1;
    lo_i = 4'h1;
    for (int i = 1; i < NUM_CELLS; i++) begin
      if (ext.cell_volt[i] >= hi_v) begin
        hi_v = ext.cell_volt[i];
        hi_i = 4'(i + 1);
      end
      if (ext.cell_volt[i] <= lo_v) begin
        lo_v = ext.cell_volt[i];
        lo_i = 4'(i + 1);
      end
    end
    ext.highest_voltage_cell = hi_i;
    ext.lowest_voltage_cell  = lo_i;
  end

endmodule

//--- cas_alert_bank_checker.sv
// concurrent checks on the register port of the alert status bank
`timescale 1ns/10ps
module cas_alert_bank_checker #(
  parameter int VOLT_W    = 14,
  parameter int NUM_CELLS = 12,
  parameter int NUM_BAL   = 12
) (
  // clock and reset
  input wire logic                             ref_clk,
  input wire logic                             rst_b,
  // register port
  input wire logic [7:0]                       reg_addr,
  input wire logic                             reg_rd_stb,
  input wire logic [15:0]                      reg_rd_data,
  // acquisition results
  input wire logic                             acq_done,
  input wire logic [NUM_CELLS-1:0][VOLT_W-1:0] cell_volt,
  input wire logic [VOLT_W-1:0]                aux0_volt,
  input wire logic [NUM_BAL-1:0][VOLT_W-1:0]   balance_diag_meas
);
  // ==========================================================================
  // one clock domain, so clock and disable are given once
  // ==========================================================================
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // read data must drop back to zero so stale values never look fresh
  property p_rd_idle; !reg_rd_stb |=> reg_rd_data == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_uv_rsvd; reg_rd_stb && reg_addr == 8'h07 |=> reg_rd_data[15:14] == 2'h0; endproperty
  a_uv_rsvd: assert property (p_uv_rsvd) else $error("cell alert spare bits set");
  property p_bal_rsvd; reg_rd_stb && reg_addr == 8'h08 |=> reg_rd_data[15:12] == 4'h0; endproperty
  a_bal_rsvd: assert property (p_bal_rsvd) else $error("balance alert spare bits set");
  property p_flt_rsvd; reg_rd_stb && reg_addr == 8'h0b |=> (reg_rd_data & 16'hfffa) == 16'h0000; endproperty
  a_flt_rsvd: assert property (p_flt_rsvd) else $error("supply fault spare bits set");
  // cell numbers run 1..12, or all ones before any acquisition
  property p_idx_rng;
    reg_rd_stb && reg_addr == 8'h0a |=> (reg_rd_data & 16'hf0f0) == 16'h0000
      && reg_rd_data[11:8] != 4'h0 && reg_rd_data[3:0] != 4'h0;
  endproperty
  a_idx_rng: assert property (p_idx_rng) else $error("cell index out of range");
  // equal readings everywhere must name the top cell for both extremes
  property p_tie;
    acq_done && cell_volt == {NUM_CELLS{cell_volt[0]}} ##6 reg_rd_stb && reg_addr == 8'h0a
      |=> reg_rd_data == {4'h0, 4'(NUM_CELLS), 4'h0, 4'(NUM_CELLS)};
  endproperty
  a_tie: assert property (p_tie) else $error("tie not resolved to top cell");
  // a full-scale reading can never sit below any threshold
  property p_aux_clr; acq_done && aux0_volt == '1 ##2 reg_rd_stb && reg_addr == 8'h07 |=> !reg_rd_data[12]; endproperty
  a_aux_clr: assert property (p_aux_clr) else $error("aux hot flag set at full scale");
  property p_cell_clr;
    acq_done && cell_volt == '1 ##2 reg_rd_stb && reg_addr == 8'h07 |=> reg_rd_data[11:0] == 12'h000;
  endproperty
  a_cell_clr: assert property (p_cell_clr) else $error("cell flag set at full scale");
  property p_bal_all;
    acq_done && balance_diag_meas == '1 ##4 reg_rd_stb && reg_addr == 8'h08 |=> reg_rd_data[11:0] == 12'hfff;
  endproperty
  a_bal_all: assert property (p_bal_all) else $error("balance flag missing at full scale");
endmodule

bind cas_alert_bank cas_alert_bank_checker #(.VOLT_W(VOLT_W), .NUM_CELLS(NUM_CELLS), .NUM_BAL(NUM_BAL)) u_chk (
  .ref_clk, .rst_b, .reg_addr, .reg_rd_stb, .reg_rd_data, .acq_done, .cell_volt, .aux0_volt, .balance_diag_meas
);

//--- tb_cell_alert_status_bank.sv
// self-checking bench for the alert status bank
`timescale 1ns/10ps
module tb_cell_alert_status_bank;
  logic                ref_clk, rst_b, reg_wr_stb, reg_rd_stb, acq_done, alert_irq;
  logic                hv_headroom_low, hv_overvoltage_pin, rd_seen = 1'b0;
  logic [7:0]          reg_addr;
  logic [15:0]         reg_wr_data, reg_rd_data;
  logic [11:0][13:0]   cell_volt, balance_diag_meas;
  logic [13:0]         aux0_volt, aux1_volt;
  logic [15:0]         exp_q[$];
  logic [31:0]         lfsr_st = 32'h4f3ecb43;
  int                  num_errors, checks_done, cyc;

  // ==========================================================================
  // clock, design and helpers
  // ==========================================================================
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  cas_alert_bank dut (.ref_clk, .rst_b, .reg_addr, .reg_wr_data, .reg_wr_stb, .reg_rd_stb, .reg_rd_data,
    .acq_done, .cell_volt, .aux0_volt, .aux1_volt, .balance_diag_meas, .hv_headroom_low,
    .hv_overvoltage_pin, .alert_irq);

  function automatic logic [31:0] lfsr_next(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(logic [15:0] got, logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // read data shows one cycle after the strobe, so compare with the oldest note then
  always @(posedge ref_clk) begin
    if (rd_seen) chk(reg_rd_data, exp_q.pop_front());
    rd_seen <= reg_rd_stb;
  end

  // cut a hang short; a full run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic rd(logic [7:0] a, logic [15:0] e);
    @(posedge ref_clk);
    reg_addr   <= a;
    reg_rd_stb <= 1'b1;
    exp_q.push_back(e);
    @(posedge ref_clk);
    reg_rd_stb <= 1'b0;
  endtask

  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge ref_clk);
    reg_addr    <= a;
    reg_wr_data <= d;
    reg_wr_stb  <= 1'b1;
    @(posedge ref_clk);
    reg_wr_stb  <= 1'b0;
  endtask

  // one acquisition, then the two flag registers and the extreme-cell register read back against worked-out values
  task automatic acq(logic [11:0][13:0] cv, bm, logic [13:0] a0, a1, thr, athr, logic [11:0] en, logic [2:0] sel,
                     logic hdr);
    logic [15:0] e7, e8;
    logic [3:0]  hi, lo;
    e7 = 16'h0000;
    e8 = 16'h0000;
    hi = 4'h1;
    lo = 4'h1;
    for (int i = 0; i < 12; i++) begin
      e7[i] = en[i] && cv[i] < thr;
      e8[i] = bm[i] > cas_pkg::BAL_DIAG_THRESH[sel];
      if (cv[i] >= cv[hi-1]) hi = 4'(i + 1);
      if (cv[i] <= cv[lo-1]) lo = 4'(i + 1);
    end
    e7[12] = a0 < athr;
    e7[13] = a1 < athr;
    @(posedge ref_clk);
    {cell_volt, balance_diag_meas, aux0_volt, aux1_volt} <= {cv, bm, a0, a1};
    hv_headroom_low <= hdr;
    acq_done        <= 1'b1;
    @(posedge ref_clk);
    acq_done        <= 1'b0;
    hv_headroom_low <= 1'b0;
    rd(8'h07, e7);
    rd(8'h08, e8);
    rd(8'h0a, {4'h0, hi, 4'h0, lo});
  endtask

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    logic [11:0][13:0] cv, bm;
    logic [11:0]       en;
    {reg_wr_stb, reg_rd_stb, acq_done, hv_headroom_low, hv_overvoltage_pin} = 5'h00;
    {reg_addr, reg_wr_data, cell_volt, balance_diag_meas, aux0_volt, aux1_volt} = '0;
    rst_b = 1'b0;
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    // reset values, refused writes and an unmapped place
    wr(8'h07, 16'hffff);
    wr(8'h0a, 16'hffff);
    rd(8'h07, 16'h0000);
    rd(8'h08, 16'h0000);
    rd(8'h0a, 16'h0f0f);
    rd(8'h0b, 16'h0000);
    rd(8'h10, 16'h0001);
    rd(8'h20, 16'h0000);
    $display("reset test done");
    // headroom flag, interrupt, write-one ignored, set beating a clear
    wr(8'h15, 16'h0008);
    acq('1, '1, '1, '1, 14'h0000, 14'h0000, 12'h000, 3'h0, 1'b1);
    chk({15'h0000, alert_irq}, 16'h0001);
    rd(8'h0b, 16'h0004);
    wr(8'h0b, 16'hffff);
    rd(8'h0b, 16'h0004);
    wr(8'h15, 16'h0000);
    rd(8'h14, 16'h000c);
    chk({15'h0000, alert_irq}, 16'h0000);
    @(posedge ref_clk);
    {reg_addr, reg_wr_data, reg_wr_stb, acq_done, hv_headroom_low} <= {8'h0b, 16'h0000, 3'h7};
    @(posedge ref_clk);
    {reg_wr_stb, acq_done, hv_headroom_low} <= 3'h0;
    rd(8'h0b, 16'h0004);
    wr(8'h0b, 16'h0000);
    rd(8'h0b, 16'h0000);
    $display("headroom test done");
    // supply overvoltage blocked by the gate, then set once the gate is cleared
    for (int g = 1; g >= 0; g--) begin
      wr(8'h10, 16'(g));
      @(posedge ref_clk);
      hv_overvoltage_pin <= 1'b1;
      repeat (6) @(posedge ref_clk);
      hv_overvoltage_pin <= 1'b0;
      rd(8'h0b, 16'(1 - g));
    end
    wr(8'h0b, 16'h0000);
    rd(8'h0b, 16'h0000);
    $display("overvoltage test done");
    // every diagnostic select, boundary measurements and random cell readings
    wr(8'h11, 16'h2000);
    wr(8'h13, 16'h1000);
    for (int s = 0; s < 8; s++) begin
      for (int i = 0; i < 12; i++) begin
        lfsr_st = lfsr_next(lfsr_st);
        cv[i]   = lfsr_st[13:0];
        bm[i]   = cas_pkg::BAL_DIAG_THRESH[s] + 14'(i % 2);
      end
      en = lfsr_st[27:16];
      wr(8'h10, {12'h000, 3'(s), 1'b0});
      wr(8'h12, {4'h0, en});
      acq(cv, bm, 14'h0fff, 14'h1000, 14'h2000, 14'h1000, en, 3'(s), 1'b0);
    end
    acq('1, '1, '1, '1, 14'h2000, 14'h1000, en, 3'h7, 1'b0);
    $display("flag test done");
    repeat (4) @(posedge ref_clk);
    close_out();
  end
endmodule
